// File: shared/dwpr_map.svh
// Purpose: Named offsets, field positions and timing counts for the
//          write/precharge/refresh command engine.
// Assumes: 10 MHz command clock.
// Notes:   Definitions only.
`ifndef DWPR_MAP_SVH
`define DWPR_MAP_SVH
`define DWPR_A10_POS        10
`define DWPR_A12_POS        12
`define DWPR_BL8_BEATS      4'h8
`define DWPR_BC4_BEATS      4'h4
`define DWPR_CWL_DEF        4'h5
`define DWPR_TWR_DEF        4'h2
`define DWPR_TRP_DEF        4'h2
`define DWPR_TRFC_DEF       8'h0B
`define DWPR_NBANK          8
`endif

// File: shared/dwpr_pkg.sv
// Purpose: Types shared by the command engine.
// Assumes: Nothing beyond the map header.
// Notes:   Command encoding is {cs_n, ras_n, cas_n, we_n}.
package dwpr_pkg;
	typedef enum logic [2:0] {
		DWPR_CMD_NOP = 3'h0,
		DWPR_CMD_WR  = 3'h1,
		DWPR_CMD_PRE = 3'h2,
		DWPR_CMD_REF = 3'h3,
		DWPR_CMD_SRE = 3'h4,
		DWPR_CMD_ACT = 3'h5
	} dwpr_cmd_t;
	typedef enum logic [1:0] {
		DWPR_BK_IDLE = 2'h0,
		DWPR_BK_OPEN = 2'h1,
		DWPR_BK_PREC = 2'h2
	} dwpr_bank_t;
	typedef enum logic [1:0] {
		DWPR_ST_RUN  = 2'h0,
		DWPR_ST_REF  = 2'h1,
		DWPR_ST_SELF = 2'h2
	} dwpr_state_t;
endpackage : dwpr_pkg

// File: src/dwpr_buf2.sv
// Purpose: Two-entry buffer between the write path and the array port.
// Assumes: Single clock; source and sink obey valid/ready.
// Notes:   Output data come from flip-flops.
`timescale 1ns/1ps
module dwpr_buf2 #(
	parameter int W = 16
) (
	input  wire logic         clk_sys_in,  // Clock
	input  wire logic         rstn_in,     // Async reset, low
	input  wire logic         s_valid_in,  // Source word valid
	output logic              s_ready_out, // Room for a word
	input  wire logic [W-1:0] s_data_in,   // Source word
	output logic              m_valid_out, // Word available
	input  wire logic         m_ready_in,  // Sink takes word
	output logic [W-1:0]      m_data_out   // Head word
);
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic         rd_r, rd_nxt, wr_r, wr_nxt;
	logic [1:0]   cnt_r, cnt_nxt;
	logic         push, pop;

	always_comb begin
		push = s_valid_in && (cnt_r != 2'h2);
		pop  = m_valid_out && m_ready_in;
		mem_nxt = mem_r;
		if (push) begin
			mem_nxt[wr_r] = s_data_in;
		end
		wr_nxt  = push ? ~wr_r : wr_r;
		rd_nxt  = pop ? ~rd_r : rd_r;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			rd_r     <= 1'b0;
			wr_r     <= 1'b0;
			cnt_r    <= 2'h0;
		end else begin
			mem_r <= mem_nxt;
			rd_r  <= rd_nxt;
			wr_r  <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign s_ready_out = (cnt_r != 2'h2);
	assign m_valid_out = (cnt_r != 2'h0);
	assign m_data_out  = mem_r[rd_r];

	chk_buf_no_over: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) cnt_r <= 2'h2)
		else $error("buffer count overflow");
endmodule : dwpr_buf2

// File: src/dwpr_core.sv
// Purpose: Command decode and bank state for write, precharge, refresh
//          and self refresh entry of a DDR3-style memory.
// Assumes: Pins synchronised here; controller keeps its timing rules.
// Notes:   Array writes leave through a two-entry buffer with back
//          pressure; data beats are taken as one byte-masked word each.
`timescale 1ns/1ps
`include "dwpr_map.svh"
module dwpr_core
	import dwpr_pkg::*;
#(
	parameter int DW = 8,
	parameter int CW = 10,
	parameter logic [3:0] CWL = `DWPR_CWL_DEF,
	parameter logic [3:0] TWR = `DWPR_TWR_DEF,
	parameter logic [3:0] TRP = `DWPR_TRP_DEF
) (
	input  wire logic          clk_sys_in,  // Clock
	input  wire logic          rstn_in,     // Async reset, low
	input  wire logic          cke_in,      // Clock enable pin
	input  wire logic          cs_n_in,     // Chip select, low
	input  wire logic          ras_n_in,    // Row strobe, low
	input  wire logic          cas_n_in,    // Column strobe, low
	input  wire logic          we_n_in,     // Write enable, low
	input  wire logic [2:0]    ba_in,       // Bank address
	input  wire logic [13:0]   addr_in,     // Address pins
	input  wire logic [DW-1:0] dq_in,       // Write data
	input  wire logic          dm_in,       // Data mask, high skips
	input  wire logic          otf_en_in,   // On-the-fly burst select
	input  wire logic          bl8_fix_in,  // Fixed length is eight
	output logic               arr_valid_out, // Array write valid
	input  wire logic          arr_ready_in,  // Array accepts
	output logic [2:0]         arr_bank_out,  // Array bank
	output logic [CW-1:0]      arr_col_out,   // Array column
	output logic [DW-1:0]      arr_data_out,  // Array byte
	output logic               data_drop_out, // Beat lost to stall
	output logic [7:0]         bank_open_out, // Open bank flags
	output logic               refresh_out,   // Refresh cycle busy
	output logic               self_ref_out,  // In self refresh
	output logic               ref_pulse_out  // Internal refresh step
);
	localparam int AW = 3 + CW + DW;

	// Two-stage pin synchronisers
	logic [20+DW:0] p1_r, p2_r;
	logic           cke_prev_r;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			p1_r       <= '1;
			p2_r       <= '1;
			cke_prev_r <= 1'b0;
		end else begin
			p1_r       <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
				ba_in, addr_in[`DWPR_A12_POS], addr_in[`DWPR_A10_POS],
				dm_in, dq_in, addr_in[9:0]};
			p2_r       <= p1_r;
			cke_prev_r <= p2_r[20+DW];
		end
	end
	wire logic          s_cke = p2_r[20+DW];
	wire logic [3:0]    s_cmd = p2_r[19+DW:16+DW];
	wire logic [2:0]    s_ba  = p2_r[15+DW:13+DW];
	wire logic          s_a12 = p2_r[12+DW];
	wire logic          s_a10 = p2_r[11+DW];
	wire logic          s_dm  = p2_r[10+DW];
	wire logic [DW-1:0] s_dq  = p2_r[9+DW:10];
	wire logic [9:0]    s_col = p2_r[9:0];

	function automatic dwpr_cmd_t decode(input logic [3:0] c,
		input logic kp, input logic kn);
		dwpr_cmd_t r;
		r = DWPR_CMD_NOP;
		if (kp) begin // Deselect and NOP fall through
			case (c)
				4'h4: r = DWPR_CMD_WR;
				4'h2: r = DWPR_CMD_PRE;
				4'h1: r = kn ? DWPR_CMD_REF : DWPR_CMD_SRE;
				4'h3: r = DWPR_CMD_ACT;
				default: r = DWPR_CMD_NOP;
			endcase
		end
		return r;
	endfunction : decode

	dwpr_cmd_t cmd;
	assign cmd = decode(s_cmd, cke_prev_r, s_cke);

	// Bank and engine state
	dwpr_bank_t  bk_r [`DWPR_NBANK];
	dwpr_bank_t  bk_nxt [`DWPR_NBANK];
	logic [3:0]  pc_r [`DWPR_NBANK];
	logic [3:0]  pc_nxt [`DWPR_NBANK];
	dwpr_state_t st_r, st_nxt;
	logic [7:0]  rfc_r, rfc_nxt;
	logic [3:0]  wl_r, wl_nxt, beat_r, beat_nxt, len_r, len_nxt;
	logic        ap_r, ap_nxt, wact_r, wact_nxt;
	logic [3:0]  rec_r, rec_nxt;
	logic        recon_r, recon_nxt;
	logic [2:0]  wba_r, wba_nxt;
	logic [CW-1:0] col_r, col_nxt;
	logic        push, buf_ready, drop_r, drop_nxt;

	always_comb begin
		bk_nxt   = bk_r;
		pc_nxt   = pc_r;
		st_nxt   = st_r;
		{rfc_nxt, wl_nxt, beat_nxt, len_nxt, ap_nxt, wact_nxt, rec_nxt,
			recon_nxt, wba_nxt, col_nxt} = {rfc_r, wl_r, beat_r, len_r,
			ap_r, wact_r, rec_r, recon_r, wba_r, col_r};
		push     = 1'b0;
		drop_nxt = 1'b0;
		for (int i = 0; i < `DWPR_NBANK; i++) begin
			if (bk_r[i] == DWPR_BK_PREC) begin
				if (pc_r[i] <= 4'h1) begin
					bk_nxt[i] = DWPR_BK_IDLE;
					pc_nxt[i] = 4'h0;
				end else begin
					pc_nxt[i] = pc_r[i] - 4'h1;
				end
			end
		end
		if (rfc_r != 8'h00) begin
			rfc_nxt = rfc_r - 8'h01;
		end
		case (st_r)
			DWPR_ST_RUN: begin
				case (cmd)
					DWPR_CMD_ACT: bk_nxt[s_ba] = DWPR_BK_OPEN;
					DWPR_CMD_WR: begin
						if (bk_r[s_ba] == DWPR_BK_OPEN && !wact_r) begin
							wact_nxt = 1'b1;
							wba_nxt  = s_ba;
							col_nxt  = CW'(s_col);
							ap_nxt   = s_a10;
							wl_nxt   = CWL;
							len_nxt  = otf_en_in ?
								(s_a12 ? `DWPR_BL8_BEATS : `DWPR_BC4_BEATS) :
								(bl8_fix_in ? `DWPR_BL8_BEATS : `DWPR_BC4_BEATS);
							beat_nxt = 4'h0;
						end
					end
					DWPR_CMD_PRE: begin
						for (int i = 0; i < `DWPR_NBANK; i++) begin
							if (s_a10 || s_ba == 3'(i)) begin
								// Idle bank stays idle; busy one restarts
								if (bk_r[i] != DWPR_BK_IDLE) begin
									bk_nxt[i] = DWPR_BK_PREC;
									pc_nxt[i] = TRP;
								end
							end
						end
					end
					DWPR_CMD_REF: begin
						st_nxt  = DWPR_ST_REF;
						rfc_nxt = `DWPR_TRFC_DEF;
					end
					DWPR_CMD_SRE: st_nxt = DWPR_ST_SELF;
					default: ;
				endcase
			end
			DWPR_ST_REF: if (rfc_r <= 8'h01) st_nxt = DWPR_ST_RUN;
			DWPR_ST_SELF: begin
				// Contents held internally, no clock edge needed
				if (s_cke && !cke_prev_r) st_nxt = DWPR_ST_RUN;
			end
			default: st_nxt = DWPR_ST_RUN;
		endcase
		if (wact_r) begin
			if (wl_r != 4'h0) begin
				wl_nxt = wl_r - 4'h1;
			end else begin
				push     = !s_dm;
				drop_nxt = !s_dm && !buf_ready;
				col_nxt  = col_r + CW'(1);
				beat_nxt = beat_r + 4'h1;
				if (beat_r + 4'h1 == len_r) begin
					wact_nxt  = 1'b0;
					recon_nxt = ap_r;
					rec_nxt   = TWR;
				end
			end
		end
		if (recon_r) begin // Runs beside other-bank commands
			if (rec_r <= 4'h1) begin
				recon_nxt    = 1'b0;
				bk_nxt[wba_r] = DWPR_BK_PREC;
				pc_nxt[wba_r] = TRP;
			end else begin
				rec_nxt = rec_r - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < `DWPR_NBANK; i++) begin
				bk_r[i] <= DWPR_BK_IDLE;
				pc_r[i] <= 4'h0;
			end
			st_r <= DWPR_ST_RUN;
			{rfc_r, wl_r, beat_r, len_r, ap_r, wact_r, rec_r, recon_r,
				wba_r, col_r, drop_r} <= '0;
		end else begin
			bk_r <= bk_nxt;
			pc_r <= pc_nxt;
			st_r <= st_nxt;
			{rfc_r, wl_r, beat_r, len_r, ap_r, wact_r, rec_r, recon_r,
				wba_r, col_r, drop_r} <= {rfc_nxt, wl_nxt, beat_nxt, len_nxt,
				ap_nxt, wact_nxt, rec_nxt, recon_nxt, wba_nxt, col_nxt, drop_nxt};
		end
	end

	logic [AW-1:0] bout;
	dwpr_buf2 #(.W(AW)) u_buf (
		.clk_sys_in  (clk_sys_in),
		.rstn_in     (rstn_in),
		.s_valid_in  (push),
		.s_ready_out (buf_ready),
		.s_data_in   ({wba_r, col_r, s_dq}),
		.m_valid_out (arr_valid_out),
		.m_ready_in  (arr_ready_in),
		.m_data_out  (bout)
	);
	assign arr_bank_out  = bout[AW-1:AW-3];
	assign arr_col_out   = bout[CW+DW-1:DW];
	assign arr_data_out  = bout[DW-1:0];
	assign data_drop_out = drop_r;
	always_comb begin
		for (int i = 0; i < `DWPR_NBANK; i++) begin
			bank_open_out[i] = (bk_r[i] == DWPR_BK_OPEN);
		end
	end
	assign refresh_out   = (st_r == DWPR_ST_REF);
	assign self_ref_out  = (st_r == DWPR_ST_SELF);
	assign ref_pulse_out = (st_r == DWPR_ST_RUN) && (cmd == DWPR_CMD_REF);

	chk_wr_open_bank: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (cmd == DWPR_CMD_WR && st_r == DWPR_ST_RUN
		&& bk_r[s_ba] == DWPR_BK_OPEN && !wact_r) |=> wact_r)
		else $error("write to open bank not started");
	chk_mask_skip: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (wact_r && wl_r == 4'h0 && s_dm
		&& !arr_valid_out) |=> !arr_valid_out)
		else $error("masked beat was stored");
	chk_pre_closes: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (st_r == DWPR_ST_RUN && cmd == DWPR_CMD_PRE
		&& s_a10) |=> bank_open_out == 8'h00)
		else $error("precharge all left a bank open");
	chk_pre_idle_nop: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (st_r == DWPR_ST_RUN && cmd == DWPR_CMD_PRE
		&& bk_r[s_ba] == DWPR_BK_IDLE && !recon_r)
		|=> bk_r[$past(s_ba)] == DWPR_BK_IDLE)
		else $error("precharge of idle bank changed it");
	chk_ref_busy: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) ref_pulse_out |=> refresh_out[*8])
		else $error("refresh cycle ended early");
	chk_self_entry: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (st_r == DWPR_ST_RUN && cmd == DWPR_CMD_SRE)
		|=> self_ref_out)
		else $error("self refresh not entered");
	chk_nop_keeps: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (wact_r && wl_r > 4'h1 && cmd == DWPR_CMD_NOP)
		|=> wact_r)
		else $error("nop disturbed a burst");
	chk_auto_pre: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (recon_r && rec_r <= 4'h1)
		|=> bk_r[$past(wba_r)] == DWPR_BK_PREC)
		else $error("auto precharge missing");
	chk_ap_flag: assert property (@(posedge clk_sys_in)
		disable iff (!rstn_in) (wact_r && wl_r == 4'h0
		&& beat_r + 4'h1 == len_r) |=> recon_r == $past(ap_r))
		else $error("auto precharge flag not followed");

	cov_write: cover property (@(posedge clk_sys_in) push);
	cov_refresh: cover property (@(posedge clk_sys_in) ref_pulse_out);
	cov_self: cover property (@(posedge clk_sys_in) self_ref_out);
	cov_stall: cover property (@(posedge clk_sys_in) !buf_ready);
endmodule : dwpr_core

// File: bench/dwpr_ctl_model.sv
// Purpose: Controller model driving command pins and write data.
// Assumes: Pins change just after a rising edge.
// Notes:   Released bank, address and data lines show the inverse of their last value; command returns to deselect.
`timescale 1ns/1ps
module dwpr_ctl_model (
	input  wire logic   clk_sys_in, // Clock
	output logic        cke_out,    // Clock enable
	output logic [3:0]  cmd_out,    // {cs_n,ras_n,cas_n,we_n}
	output logic [2:0]  ba_out,     // Bank address
	output logic [13:0] addr_out,   // Address
	output logic [7:0]  dq_out,     // Write data
	output logic        dm_out      // Data mask
);
	initial begin
		cke_out = 1'b0;
		cmd_out = 4'hF;
		ba_out = 3'h0;
		addr_out = 14'h0000;
		dq_out = 8'h00;
		dm_out = 1'b0;
	end
	// One command cycle, then deselect
	task automatic issue(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a, input logic ck);
		@(posedge clk_sys_in);
		cke_out <= ck;
		cmd_out <= c;
		ba_out <= b;
		addr_out <= a;
		@(posedge clk_sys_in);
		cmd_out <= 4'hF;
		ba_out <= ~b;
		addr_out <= ~a;
	endtask : issue
	// Beats start six pin cycles after the command
	task automatic burst(input logic [63:0] d, input logic [7:0] m,
		input int n);
		repeat (4) @(posedge clk_sys_in);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_in);
			dq_out <= d[8*i +: 8];
			dm_out <= m[i];
		end
		@(posedge clk_sys_in);
		dq_out <= ~dq_out;
		dm_out <= ~dm_out;
	endtask : burst
endmodule : dwpr_ctl_model

// File: bench/tb.sv
// Purpose: Self-checking bench for the command engine.
// Assumes: Default latencies of the core; array sink is the bench.
// Notes:   Controller timing is kept by the scenarios themselves.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
	import dwpr_pkg::*;
	logic        clk_sys_in;
	logic        rstn_r;
	logic        otf_r;
	logic        bl8_r;
	logic        rdy_r;
	wire         cke;
	wire  [3:0]  cmd;
	wire  [2:0]  ba;
	wire  [13:0] addr;
	wire  [7:0]  dq;
	wire         dm;
	logic        av;
	logic [2:0]  abank;
	logic [9:0]  acol;
	logic [7:0]  adata;
	logic        drop;
	logic [7:0]  bopen;
	logic        refr;
	logic        selfr;
	logic        rpulse;
	logic [20:0] got_q[$];
	int          drops;
	int          error_cnt = 0;
	int          samples_checked = 0;

	dwpr_ctl_model ctl (.clk_sys_in(clk_sys_in), .cke_out(cke),
		.cmd_out(cmd), .ba_out(ba), .addr_out(addr), .dq_out(dq),
		.dm_out(dm));
	dwpr_core dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_r),
		.cke_in(cke), .cs_n_in(cmd[3]), .ras_n_in(cmd[2]),
		.cas_n_in(cmd[1]), .we_n_in(cmd[0]), .ba_in(ba),
		.addr_in(addr), .dq_in(dq), .dm_in(dm), .otf_en_in(otf_r),
		.bl8_fix_in(bl8_r), .arr_valid_out(av), .arr_ready_in(rdy_r),
		.arr_bank_out(abank), .arr_col_out(acol), .arr_data_out(adata),
		.data_drop_out(drop), .bank_open_out(bopen),
		.refresh_out(refr), .self_ref_out(selfr),
		.ref_pulse_out(rpulse));

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		if (av === 1'b1 && rdy_r === 1'b1)
			got_q.push_back({abank, acol, adata});
		if (drop === 1'b1)
			drops++;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	task automatic act(input logic [2:0] b);
		ctl.issue(4'h3, b, 14'h0000, 1'b1);
		repeat (3) @(posedge clk_sys_in);
	endtask : act
	task automatic wr(input logic [2:0] b, input logic [13:0] a,
		input logic [63:0] d, input logic [7:0] m, input int n);
		ctl.issue(4'h4, b, a, 1'b1);
		ctl.burst(d, m, n);
		repeat (6) @(posedge clk_sys_in);
	endtask : wr
	// Compares queued array words with the unmasked beats
	task automatic expect_words(input logic [2:0] b, input logic [9:0] c,
		input logic [63:0] d, input logic [7:0] m, input int n);
		logic [20:0] w;
		logic [20:0] g;
		for (int i = 0; i < n; i++) begin
			if (!m[i]) begin
				w = {b, c + 10'(i), d[8*i +: 8]};
				g = (got_q.size() > 0) ? got_q.pop_front() : 21'h0;
				`CHK("array word", w, g)
			end
		end
		`CHK("extra words", 0, got_q.size())
	endtask : expect_words

	task automatic t_write_bl8();
		act(3'h2);
		`CHK("bank2 open", 1'b1, bopen[2])
		wr(3'h2, 14'h1010, 64'h8877665544332211, 8'h24, 8);
		expect_words(3'h2, 10'h010, 64'h8877665544332211, 8'h24, 8);
		`CHK("row kept", 1'b1, bopen[2])
		$display("test write_bl8 done");
	endtask : t_write_bl8
	task automatic t_write_bc4_ap();
		wr(3'h2, 14'h0420, 64'hF0E0D0C0B0A09080, 8'h00, 8);
		expect_words(3'h2, 10'h020, 64'hF0E0D0C0B0A09080, 8'h00, 4);
		repeat (6) @(posedge clk_sys_in);
		`CHK("auto precharge", 8'h00, bopen)
		$display("test write_bc4_ap done");
	endtask : t_write_bc4_ap
	task automatic t_fixed_len();
		otf_r <= 1'b0;
		bl8_r <= 1'b0;
		act(3'h3);
		wr(3'h3, 14'h1030, 64'h0102030405060708, 8'h01, 8);
		expect_words(3'h3, 10'h030, 64'h0102030405060708, 8'h01, 4);
		wr(3'h5, 14'h0040, 64'h0102030405060708, 8'h00, 8);
		`CHK("closed bank write", 0, got_q.size())
		bl8_r <= 1'b1;
		wr(3'h3, 14'h0050, 64'h2122232425262728, 8'h00, 8);
		expect_words(3'h3, 10'h050, 64'h2122232425262728, 8'h00, 8);
		otf_r <= 1'b1;
		$display("test fixed_len done");
	endtask : t_fixed_len
	task automatic t_precharge();
		act(3'h1);
		act(3'h4);
		act(3'h6);
		ctl.issue(4'h2, 3'h1, 14'h0000, 1'b1);
		repeat (6) @(posedge clk_sys_in);
		`CHK("single precharge", 8'h58, bopen)
		ctl.issue(4'h2, 3'h1, 14'h0000, 1'b1);
		repeat (6) @(posedge clk_sys_in);
		`CHK("idle precharge", 8'h58, bopen)
		ctl.issue(4'h2, 3'h1, 14'h0400, 1'b1);
		repeat (6) @(posedge clk_sys_in);
		`CHK("precharge all", 8'h00, bopen)
		$display("test precharge done");
	endtask : t_precharge
	task automatic t_refresh();
		int np;
		int nr;
		np = 0;
		nr = 0;
		fork
			ctl.issue(4'h1, 3'h7, 14'h3FFF, 1'b1);
			repeat (24) @(negedge clk_sys_in) begin
				np += (rpulse === 1'b1);
				nr += (refr === 1'b1);
			end
			begin
				repeat (4) @(posedge clk_sys_in);
				ctl.issue(4'h3, 3'h0, 14'h0000, 1'b1);
			end
		join
		`CHK("refresh steps", 1, np)
		`CHK("refresh cycles", 11, nr)
		`CHK("ignored activate", 8'h00, bopen)
		$display("test refresh done");
	endtask : t_refresh
	task automatic t_self();
		// Nothing posted; cke held low from entry until the exit command, clock kept running
		ctl.issue(4'h1, 3'h0, 14'h0000, 1'b0);
		repeat (5) @(posedge clk_sys_in);
		`CHK("self entry", 1'b1, selfr)
		ctl.issue(4'h3, 3'h0, 14'h0000, 1'b0);
		repeat (5) @(posedge clk_sys_in);
		`CHK("self hold", 1'b1, selfr)
		ctl.issue(4'h7, 3'h0, 14'h0000, 1'b1);
		repeat (5) @(posedge clk_sys_in);
		`CHK("self exit", 1'b0, selfr)
		`CHK("banks idle", 8'h00, bopen)
		$display("test self done");
	endtask : t_self
	task automatic t_stall();
		rdy_r <= 1'b0;
		drops = 0;
		act(3'h0);
		wr(3'h0, 14'h1000, 64'h1F1E1D1C1B1A1918, 8'h00, 8);
		`CHK("lost beats", 6, drops)
		rdy_r <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		expect_words(3'h0, 10'h000, 64'h1F1E1D1C1B1A1918, 8'h00, 2);
		$display("test stall done");
	endtask : t_stall

	initial begin
		rstn_r = 1'b0;
		otf_r = 1'b1;
		bl8_r = 1'b1;
		rdy_r = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rstn_r <= 1'b1;
		ctl.issue(4'hF, 3'h0, 14'h0000, 1'b1);
		repeat (4) @(posedge clk_sys_in);
		t_write_bl8();
		t_write_bc4_ap();
		t_fixed_len();
		t_precharge();
		t_refresh();
		t_self();
		t_stall();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		error_cnt++;
		give_verdict();
	end
endmodule : tb
